/* File: rtl/fbc_pkg.sv */
// Constants, types and register map of the flash bank erase/program controller
package fbc_pkg;

  // Register bus geometry
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 8;

  // Register offsets
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;  // flash_control_register
  localparam logic [REG_AW-1:0] OFS_PROT = 8'h04;  // protect_start_register
  localparam logic [REG_AW-1:0] OFS_STAT = 8'h08;  // Sequence status

  // Control register field positions
  localparam int unsigned CTRL_PGM  = 0;  // program_select
  localparam int unsigned CTRL_ERS  = 1;  // Erase select
  localparam int unsigned CTRL_MASS = 2;  // Mass erase select
  localparam int unsigned CTRL_HV   = 3;  // high_voltage_enable

  // Status register field positions
  localparam int unsigned STAT_PROT_RD  = 0;  // Protect register read in this sequence
  localparam int unsigned STAT_LATCHED  = 1;  // Page or row address latched
  localparam int unsigned STAT_NVS_DONE = 2;  // Setup time elapsed since latch
  localparam int unsigned STAT_ROW_FAIL = 3;  // Program write left the row
  localparam int unsigned STAT_PROT_HIT = 4;  // Latched address is protected
  localparam int unsigned STAT_STANDBY  = 5;  // Flash held in standby
  localparam int unsigned STAT_HV_REF   = 6;  // High-voltage request refused

  // Reset values
  localparam logic [REG_DW-1:0] CTRL_RST = 8'h00;
  localparam logic [REG_DW-1:0] PROT_RST = 8'hff;

  // Flash geometry
  localparam int unsigned FA_W      = 16;  // Array address width
  localparam int unsigned ROW_LSB   = 6;   // 64-byte rows
  localparam int unsigned PROT_LSB  = 7;   // Protect bits land at [14:7]
  localparam logic [FA_W-1:0] ARRAY_END = 16'h7fff;
  localparam logic [REG_DW-1:0] PROT_NONE = 8'hff;

  // Timing: latch to high voltage setup time
  localparam int unsigned CLK_MHZ     = 50;
  localparam int unsigned NVS_TIME_NS = 10000;  // latch_to_hv_setup_time, 10 us
  localparam int unsigned NVS_CYC     = (NVS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NVS_CW      = 10;

  // Sequence states
  typedef enum logic [2:0] {
    FBC_IDLE,      // Read mode, no operation selected
    FBC_SELECTED,  // Program or erase selected
    FBC_PROT_RD,   // Protect register has been read
    FBC_LATCHED,   // Target address latched, setup running
    FBC_HV_ON      // High voltage applied
  } fbc_state_t;

endpackage

/* File: rtl/fbc_row_if.sv */
// Interface between the sequencer and its row guard
`timescale 1ns/10ps
interface fbc_row_if;
  import fbc_pkg::*;
  logic            latch_wr;  // Latch the target row
  logic            prog_wr;   // Data byte write during programming
  logic            clear;     // End of sequence, clear the row failure flag
  logic [FA_W-1:0] addr;      // Array address of the write
  logic            fail;      // Cycle touched a second row
  logic            same_row;  // Current address lies in latched row

  modport seq   (output latch_wr, prog_wr, clear, addr, input fail, same_row);
  modport guard (input latch_wr, prog_wr, clear, addr, output fail, same_row);
endinterface

/* File: rtl/fbc_row_guard.sv */
// Row guard: holds the latched row and flags writes outside it
`timescale 1ns/10ps
module fbc_row_guard
  import fbc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  fbc_row_if.guard  row
);

  // Latched row number within the array
  logic [FA_W-ROW_LSB-1:0] row_q;
  // Sticky failure of the current cycle
  logic                    fail_q;

  // Row comparison on aligned 64-byte boundaries
  assign row.same_row = (row.addr[FA_W-1:ROW_LSB] == row_q);
  assign row.fail     = fail_q;

  // Row register, captured by the latch write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= '0;
    end else if (row.latch_wr) begin
      row_q <= row.addr[FA_W-1:ROW_LSB];
    end
  end

  // Failure flag, set by a write into another row; set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_q <= 1'b0;
    end else if (row.prog_wr && !row.same_row) begin
      fail_q <= 1'b1;
    end else if (row.clear) begin
      fail_q <= 1'b0;
    end
  end

endmodule

/* File: rtl/fbc_ctrl.sv */
// Flash bank erase/program sequencer with register port and flash controls
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module fbc_ctrl
  import fbc_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // Register port
  input  wire logic [fbc_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [fbc_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [fbc_pkg::REG_DW-1:0] reg_rdata,
  // Processor writes into the flash array space
  input  wire logic                     arr_wr,
  input  wire logic [fbc_pkg::FA_W-1:0] arr_addr,
  input  wire logic [7:0]               arr_wdata,
  // Low-power mode requests
  input  wire logic                     wait_mode,
  input  wire logic                     stop_mode,
  // Controls toward the flash macro
  output logic                          fl_erase,
  output logic                          fl_mass,
  output logic                          fl_prog,
  output logic                          fl_hv,
  output logic                          fl_byte_wr,
  output logic      [fbc_pkg::FA_W-1:0] fl_addr,
  output logic      [7:0]               fl_data
);
  import fbc_pkg::*;

  // Protected range test on a 16-bit array address
  function automatic logic is_protected(input logic [FA_W-1:0] a,
                                        input logic [REG_DW-1:0] p);
    logic [FA_W-1:0] start;
    start = {1'b0, p, 7'h00};
    is_protected = (p != PROT_NONE) && (a >= start) && (a <= ARRAY_END);
  endfunction

  // Register state
  fbc_state_t          st_q;        // Sequence state
  logic                pgm_q;       // program_select
  logic                ers_q;       // Erase select
  logic                mass_q;      // Mass erase select
  logic                hv_q;        // high_voltage_enable
  logic [REG_DW-1:0]   prot_q;      // protect_start_register
  logic [NVS_CW-1:0]   nvs_cnt_q;   // Setup time counter
  logic                nvs_done;    // Setup time reached
  logic [FA_W-1:0]     lat_addr_q;  // Latched page or row address
  logic                hv_ref_q;    // Sticky refused high-voltage request
  logic [REG_DW-1:0]   rdata_q;     // Registered read data
  logic                standby;     // Wait or stop in force
  logic                prot_hit;    // Latched address is protected

  // Bus decode
  logic wr_ctrl;
  logic wr_prot;
  logic rd_prot;
  logic set_pgm;
  logic set_ers;
  logic hv_req;
  logic hv_ok;
  logic op_sel;

  // Byte write strobes toward the guard
  logic latch_wr;
  logic prog_wr;

  fbc_row_if row_if ();

  // Register strobes decoded from the byte offset
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_prot = reg_wr && (reg_addr == OFS_PROT);
  // A protect read is the step that arms the latch write
  assign rd_prot = reg_rd && (reg_addr == OFS_PROT);

  // Either low-power mode parks the flash in standby
  assign standby = wait_mode || stop_mode;

  // An operation is under way while either select bit is set
  assign op_sel  = pgm_q || ers_q;

  // Protection is judged on the latched target, not on later bytes
  assign prot_hit = is_protected(lat_addr_q, prot_q);

  // Setup time is complete once the counter has reached its end count
  assign nvs_done = (nvs_cnt_q == NVS_CW'(NVS_CYC));

  // Select bits: one may only rise while the other stays low
  assign set_pgm = reg_wdata[CTRL_PGM] && !reg_wdata[CTRL_ERS] && !ers_q;
  assign set_ers = reg_wdata[CTRL_ERS] && !reg_wdata[CTRL_PGM] && !pgm_q;

  // High voltage accepted only after the full step order and outside protection
  assign hv_req = wr_ctrl && reg_wdata[CTRL_HV] && !hv_q;
  assign hv_ok  = op_sel && (st_q == FBC_LATCHED) && nvs_done
                  && !prot_hit && !standby;

  // Flash-space writes: first is the latch write, later ones in a program sequence are data bytes
  assign latch_wr = arr_wr && !standby && op_sel && (st_q == FBC_PROT_RD);
  // Data bytes only count while high voltage is actually on
  assign prog_wr  = arr_wr && !standby && pgm_q && hv_q && (st_q == FBC_HV_ON);

  // The guard clears its failure flag whenever the sequence is back in read mode
  assign row_if.latch_wr = latch_wr;
  assign row_if.prog_wr  = prog_wr;
  assign row_if.clear    = (st_q == FBC_IDLE);
  assign row_if.addr     = arr_addr;

  // Row tracking for program cycles
  fbc_row_guard u_guard (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .row     (row_if)
  );

  // Program select bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pgm_q <= CTRL_RST[CTRL_PGM];
    end else if (wr_ctrl) begin
      // Once set the bit follows the written value; setting obeys the interlock
      pgm_q <= pgm_q ? reg_wdata[CTRL_PGM] : set_pgm;
    end
  end

  // Erase and mass erase select bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ers_q  <= CTRL_RST[CTRL_ERS];
      mass_q <= CTRL_RST[CTRL_MASS];
    end else if (wr_ctrl) begin
      // Same interlock as program select, seen from the other side
      ers_q  <= ers_q ? reg_wdata[CTRL_ERS] : set_ers;
      // Mass select is a plain stored bit
      mass_q <= reg_wdata[CTRL_MASS];
    end
  end

  // High-voltage enable: set only when allowed, clear at any time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_q <= CTRL_RST[CTRL_HV];
    end else if (wr_ctrl) begin
      // Dropping high voltage is always honoured
      if (!reg_wdata[CTRL_HV]) begin
        hv_q <= 1'b0;
      // Raising it needs the whole step order behind it
      end else if (hv_req && hv_ok) begin
        hv_q <= 1'b1;
      end
      // A refused raise leaves the bit low; the status flag reports it
    end
  end

  // Refused high-voltage requests are remembered until the sequence is back in read mode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_ref_q <= 1'b0;
    end else if (hv_req && !hv_ok) begin
      hv_ref_q <= 1'b1;
    end else if (st_q == FBC_IDLE) begin
      // Back in read mode the record is dropped; a refusal in that cycle wins
      hv_ref_q <= 1'b0;
    end
  end

  // Protect start register, written through the port
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prot_q <= PROT_RST;
    end else if (wr_prot) begin
      // Writable stand-in for the protect byte
      prot_q <= reg_wdata;
    end
  end

  // Sequence state; frozen while in standby
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= FBC_IDLE;
    end else if (!standby) begin
      unique case (st_q)
        // Read mode until a select bit is set
        FBC_IDLE: begin
          if (op_sel) begin
            st_q <= FBC_SELECTED;
          end
        end
        // Selected; the protect read must come before any latch write
        FBC_SELECTED: begin
          if (!op_sel) begin
            st_q <= FBC_IDLE;
          end else if (rd_prot) begin
            st_q <= FBC_PROT_RD;
          end
        end
        // Next flash-space write picks the page or row
        FBC_PROT_RD: begin
          if (!op_sel) begin
            st_q <= FBC_IDLE;
          end else if (latch_wr) begin
            st_q <= FBC_LATCHED;
          end
        end
        // Setup time runs; only an accepted raise moves on
        FBC_LATCHED: begin
          if (!op_sel) begin
            st_q <= FBC_IDLE;
          end else if (hv_req && hv_ok) begin
            st_q <= FBC_HV_ON;
          end
        end
        // High voltage phase of program or erase
        FBC_HV_ON: begin
          // Operation ends once both select and high voltage are low
          if (!op_sel && !hv_q) begin
            st_q <= FBC_IDLE;
          end
        end
        // Codes outside the state list fall back to read mode
        default: begin
          st_q <= FBC_IDLE;
        end
      endcase
    end
  end

  // Latched target address, page for erase and row for program
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_addr_q <= '0;
    end else if (latch_wr) begin
      // Held for the protection test for the rest of the sequence
      lat_addr_q <= arr_addr;
    end
  end

  // Setup timer from latch write to permitted high voltage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvs_cnt_q <= '0;
    end else if (st_q != FBC_LATCHED) begin
      // Any other state restarts the count
      nvs_cnt_q <= '0;
    end else if (!nvs_done) begin
      // Count up and hold at the end count
      nvs_cnt_q <= nvs_cnt_q + NVS_CW'(1);
    end
  end

  // Flash control outputs, all forced inactive in standby
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_erase <= 1'b0;
      fl_mass  <= 1'b0;
      fl_prog  <= 1'b0;
      fl_hv    <= 1'b0;
    end else begin
      // Erase, program and high voltage follow their register bits one cycle later, gated by standby
      fl_erase <= ers_q && !standby;
      // Mass erase only means something beside erase select
      fl_mass  <= ers_q && mass_q && !standby;
      fl_prog  <= pgm_q && !standby;
      fl_hv    <= hv_q && !standby;
    end
  end

  // Address, data and byte strobe toward the array
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_byte_wr <= 1'b0;
      fl_addr    <= '0;
      fl_data    <= 8'hff;
    end else begin
      // Bytes outside the latched row are dropped and fail the cycle
      fl_byte_wr <= prog_wr && row_if.same_row && !row_if.fail;
      // Address and data are held between writes for the array to sample
      if (latch_wr || prog_wr) begin
        fl_addr <= arr_addr;
        fl_data <= arr_wdata;
      end
    end
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        // Control bits read back as stored; upper bits read as zero
        OFS_CTRL: rdata_q <= {4'h0, hv_q, mass_q, ers_q, pgm_q};
        OFS_PROT: rdata_q <= prot_q;
        // Refusal, standby, protection, row failure, setup, latch, protect read
        OFS_STAT: rdata_q <= {1'b0, hv_ref_q, standby, prot_hit, row_if.fail,
                              nvs_done, (st_q == FBC_LATCHED) || (st_q == FBC_HV_ON),
                              st_q != FBC_IDLE && st_q != FBC_SELECTED};
        default:  rdata_q <= '0;
      endcase
    end else begin
      // Read data stand for one cycle only
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

/* File: verif/fbc_properties.sv */
// Port-level checker of the flash sequencer, bound to its top module
`timescale 1ns/10ps
module fbc_props
  import fbc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        arr_wr,
  input wire logic [15:0] arr_addr,
  input wire logic [7:0]  arr_wdata,
  input wire logic        wait_mode,
  input wire logic        stop_mode,
  input wire logic        fl_erase,
  input wire logic        fl_mass,
  input wire logic        fl_prog,
  input wire logic        fl_hv,
  input wire logic        fl_byte_wr,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0]  fl_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [9:0] row_q;   // Row of the last programmed byte
  logic       have_q;  // A byte went out in this program sequence

  // Remember the row in use; forget it once program select drops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_q  <= 10'h000;
      have_q <= 1'b0;
    end else begin
      if (fl_byte_wr) row_q <= fl_addr[15:6];
      have_q <= fl_prog & (have_q | fl_byte_wr);
    end
  end

  sel_excl_a: assert property (!(fl_erase && fl_prog))
    else $error("erase and program selected together");
  hv_cause_a: assert property ($rose(fl_hv) |->
    (fl_prog || fl_erase) &&
    (($past(reg_wr, 2) && $past(reg_wdata[CTRL_HV], 2)) || $past(wait_mode || stop_mode, 2)))
    else $error("high voltage rose without selection and request");
  standby_off_a: assert property ((wait_mode || stop_mode) |=>
    !(fl_hv || fl_prog || fl_erase || fl_mass || fl_byte_wr))
    else $error("flash control active in standby");
  byte_cause_a: assert property (fl_byte_wr |-> $past(arr_wr) && fl_prog && fl_hv)
    else $error("byte strobe without programming write");
  byte_addr_a: assert property (fl_byte_wr |-> fl_addr == $past(arr_addr))
    else $error("byte address not latched");
  byte_data_a: assert property (fl_byte_wr |-> fl_data == $past(arr_wdata))
    else $error("byte data not latched");
  one_row_a: assert property (fl_byte_wr && have_q |-> fl_addr[15:6] == row_q)
    else $error("programmed byte left its row");
  erase_no_byte_a: assert property (fl_erase |-> !fl_byte_wr)
    else $error("byte strobe during erase");

  cover property (fl_byte_wr);
  cover property ($rose(fl_hv) && fl_erase);
  cover property (fl_hv ##1 wait_mode);
endmodule

bind fbc_ctrl fbc_props u_fbc_props (.*);

/* File: verif/tb_top.sv */
// Self-checking bench of the flash sequencer
`timescale 1ns/10ps
module tb_top;
  import fbc_pkg::*;
  logic        sys_clk = 1'b0;       // 50 MHz clock
  logic        rst_n = 1'b0;         // Reset, active low
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        arr_wr = 1'b0;
  logic [15:0] arr_addr = 16'h0000;
  logic [7:0]  arr_wdata = 8'h00;
  logic        wait_mode = 1'b0;
  logic        stop_mode = 1'b0;
  logic        fl_erase, fl_mass, fl_prog, fl_hv, fl_byte_wr;
  logic [15:0] fl_addr;
  logic [7:0]  fl_data;
  logic [7:0]  d;                    // Read data
  int          err_count = 0;
  int          samples_checked = 0;
  int          byte_cnt = 0;         // Byte strobes seen
  logic [23:0] last_byte = 24'h0;    // Address and data of last strobe

  fbc_ctrl u_fbc_ctrl (.*);

  initial forever #10 sys_clk = ~sys_clk;

  // Log every byte handed to the flash
  always @(posedge sys_clk) begin
    if (fl_byte_wr === 1'b1) begin
      byte_cnt++;
      last_byte = {fl_addr, fl_data};
    end
  end

  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m);
    rd(a);
    chk(nm, e, d & m);
  endtask

  task automatic aw(input logic [15:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    arr_addr  <= a;
    arr_wdata <= v;
    arr_wr    <= 1'b1;
    @(posedge sys_clk);
    arr_wr <= 1'b0;
  endtask

  // Cut a hung run short
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk("ctrl", OFS_CTRL, CTRL_RST, 8'hff);
    rchk("protect", OFS_PROT, PROT_RST, 8'hff);
    rchk("unmapped", 8'h0c, 8'h00, 8'hff);
    chk("fl_data", 8'hff, fl_data);
    // Program a row: early request, two row edges, one stray byte
    wr(OFS_CTRL, 8'h01);
    tick(1);
    chk("fl_prog", 1'b1, fl_prog);
    rd(OFS_PROT);
    aw(16'h1247, 8'h00);
    wr(OFS_CTRL, 8'h09);
    tick(1);
    chk("early hv", 1'b0, fl_hv);
    rchk("hv refused", OFS_STAT, 8'h40, 8'h40);
    tick(NVS_CYC);
    wr(OFS_CTRL, 8'h09);
    tick(250);
    chk("fl_hv", 1'b1, fl_hv);
    for (int i = 0; i < 2; i++) begin
      aw(i ? 16'h127f : 16'h1240, 8'h5a ^ i[7:0]);
      tick(1500);
    end
    chk("last byte", {16'h127f, 8'h5b}, last_byte);
    aw(16'h1280, 8'h00);
    tick(2);
    chk("bytes", 2, byte_cnt);
    rchk("row fail", OFS_STAT, 8'h08, 8'h08);
    wr(OFS_CTRL, 8'h08);
    tick(250);
    wr(OFS_CTRL, 8'h00);
    tick(50);
    chk("prog end", 2'b00, {fl_prog, fl_hv});
    // Select interlock both ways, then mass select
    for (int s = 1; s < 3; s++) begin
      wr(OFS_CTRL, s[7:0]);
      wr(OFS_CTRL, 8'h03);
      tick(1);
      chk("interlock", s[1:0], {fl_erase, fl_prog});
      wr(OFS_CTRL, 8'h00);
    end
    wr(OFS_CTRL, 8'h06);
    tick(1);
    chk("mass", 2'b11, {fl_mass, fl_erase});
    wr(OFS_CTRL, 8'h00);
    // Erase inside, then just below, the protected range
    wr(OFS_PROT, 8'hfe);
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, 8'h02);
      rd(OFS_PROT);
      aw(p ? 16'h7eff : 16'h7f00, 8'h33);
      tick(NVS_CYC + 5);
      wr(OFS_CTRL, 8'h0a);
      tick(1);
      chk("erase hv", p[0], fl_hv);
      if (p == 0) begin
        rchk("protected", OFS_STAT, 8'h10, 8'h10);
        wr(OFS_CTRL, 8'h00);
        tick(5);
      end
    end
    chk("page latch", 16'h7eff, fl_addr);
    // Wait and stop both put the flash in standby
    for (int m = 1; m < 3; m++) begin
      @(posedge sys_clk);
      {stop_mode, wait_mode} <= m[1:0];
      tick(2);
      chk("standby", 5'h00, {fl_erase, fl_mass, fl_prog, fl_hv, fl_byte_wr});
      rchk("standby flag", OFS_STAT, 8'h20, 8'h20);
      @(posedge sys_clk);
      {stop_mode, wait_mode} <= 2'b00;
      tick(2);
    end
    tick(50000);
    wr(OFS_CTRL, 8'h08);
    tick(250);
    wr(OFS_CTRL, 8'h00);
    tick(10);
    chk("erase end", 2'b00, {fl_erase, fl_hv});
    stop_test();
  end
endmodule
